// >>> logic/tmrcc_map.vh
// Register offsets, field positions, reset values for the capture/match timer.
// Assumes inclusion by bare name from the timer design and verification files.
`ifndef TMRCC_MAP_VH
`define TMRCC_MAP_VH

// ==========================================================================
// Register byte offsets
`define TMRCC_IR_OFF       8'h00
`define TMRCC_TCR_OFF      8'h04
`define TMRCC_TC_OFF       8'h08
`define TMRCC_PR_OFF       8'h0c
`define TMRCC_PC_OFF       8'h10
`define TMRCC_MCR_OFF      8'h14
`define TMRCC_CCR_OFF      8'h18
`define TMRCC_EMR_OFF      8'h1c
`define TMRCC_MR0_OFF      8'h20
`define TMRCC_CR0_OFF      8'h30
`define TMRCC_CTCR_OFF     8'h40
`define TMRCC_IMR_OFF      8'h44
`define TMRCC_CROUTE_OFF   8'h48
`define TMRCC_PROUTE_OFF   8'h4c

// ==========================================================================
// Field positions
`define TMRCC_TCR_EN       0
`define TMRCC_TCR_RST      1
`define TMRCC_MCR_INT      0
`define TMRCC_MCR_RST      1
`define TMRCC_MCR_STOP     2
`define TMRCC_CCR_RISE     0
`define TMRCC_CCR_FALL     1
`define TMRCC_CCR_INT      2
`define TMRCC_EMR_ACT      4
`define TMRCC_CTCR_SEL     2

// ==========================================================================
// Reset values and encodings
`define TMRCC_CROUTE_RST   32'h80402010
`define TMRCC_PROUTE_RST   16'he4e4
`define TMRCC_MODE_TIMER   2'h0
`define TMRCC_ACT_NONE     2'h0
`define TMRCC_ACT_LOW      2'h1
`define TMRCC_ACT_HIGH     2'h2
`define TMRCC_ACT_TOGGLE   2'h3
`define TMRCC_RESP_OKAY    2'h0
`define TMRCC_RESP_SLVERR  2'h2

`endif

// >>> logic/tmrcc_edge.v
// Edge detector for one capture or count signal.
// Assumes the input is already synchronous to aclk.
module tmrcc_edge (
  input  wire aclk,     // Peripheral clock.
  input  wire aresetn,  // Synchronous reset, active low.
  input  wire sig,      // Level to watch.
  input  wire rise_en,  // Report rising edges.
  input  wire fall_en,  // Report falling edges.
  output wire evt       // One-cycle pulse on a selected edge.
);
  reg prev_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sig;
    end
  end

  assign evt = (rise_en & sig & ~prev_q) | (fall_en & ~sig & prev_q);
endmodule // tmrcc_edge

// >>> logic/tmrcc_emout.v
// One external match output with its on-match action.
// Assumes hit is a one-cycle pulse from the counter logic.
`include "tmrcc_map.vh"
module tmrcc_emout (
  input  wire       aclk,     // Peripheral clock.
  input  wire       aresetn,  // Synchronous reset, active low.
  input  wire       hit,      // Match event pulse.
  input  wire [1:0] act,      // Action taken on a match.
  input  wire       sw_wr,    // Software writes the output level.
  input  wire       sw_val,   // Level written by software.
  output reg        out_q     // Match output level.
);
  // A match in the same cycle as a software write wins.
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 1'b0;
    end else if (hit) begin
      case (act)
        `TMRCC_ACT_LOW:    out_q <= 1'b0;
        `TMRCC_ACT_HIGH:   out_q <= 1'b1;
        `TMRCC_ACT_TOGGLE: out_q <= ~out_q;
        default:           out_q <= out_q;
      endcase
    end else if (sw_wr) begin
      out_q <= sw_val;
    end
  end
endmodule // tmrcc_emout

// >>> logic/tmrcc_top.v
// Capture/match timer with AXI4-Lite register access.
// Assumes pin inputs are synchronous to aclk and a single AXI4-Lite master.
// Operation
// - 32-bit counter behind 32-bit prescaler, clock or events
// - Four match values, continue counting, optional interrupt
// - Per match option to stop counter
// - Per match option to reset counter
// - Four captures latch count on input edges
// - Match outputs go low, high, toggle, or hold
// - External count clock from one selected capture input
// - Other captures keep working while one counts
// - Several pins combine into capture; broadcast match
// - All flags merge into one interrupt line
`include "tmrcc_map.vh"
module tmrcc_top (
  input  wire        aclk,           // Peripheral clock, 20 MHz.
  input  wire        aresetn,        // Synchronous reset, active low.
  input  wire [7:0]  s_axi_awaddr,   // Write address.
  input  wire [2:0]  s_axi_awprot,   // Unused protection bits.
  input  wire        s_axi_awvalid,  // Write address valid.
  output wire        s_axi_awready,  // Write address ready.
  input  wire [31:0] s_axi_wdata,    // Write data.
  input  wire [3:0]  s_axi_wstrb,    // Write byte strobes.
  input  wire        s_axi_wvalid,   // Write data valid.
  output wire        s_axi_wready,   // Write data ready.
  output reg  [1:0]  s_axi_bresp,    // Write response.
  output reg         s_axi_bvalid,   // Write response valid.
  input  wire        s_axi_bready,   // Write response ready.
  input  wire [7:0]  s_axi_araddr,   // Read address.
  input  wire [2:0]  s_axi_arprot,   // Unused protection bits.
  input  wire        s_axi_arvalid,  // Read address valid.
  output wire        s_axi_arready,  // Read address ready.
  output reg  [31:0] s_axi_rdata,    // Read data.
  output reg  [1:0]  s_axi_rresp,    // Read response.
  output reg         s_axi_rvalid,   // Read data valid.
  input  wire        s_axi_rready,   // Read data ready.
  input  wire [7:0]  capture_input,  // Capture and count pins.
  output wire [3:0]  match_output,   // One output per match value.
  output wire [7:0]  match_pin,      // Routed copies of match outputs.
  output wire        irq             // Level interrupt request.
);
  // ========================================================================
  // Storage
  reg  [7:0]  ir_q;
  reg  [7:0]  imr_q;
  reg  [1:0]  tcr_q;
  reg  [31:0] tc_q;
  reg  [31:0] pr_q;
  reg  [31:0] pc_q;
  reg  [11:0] mcr_q;
  reg  [11:0] ccr_q;
  reg  [7:0]  emr_act_q;
  reg  [3:0]  ctcr_q;
  reg  [31:0] croute_q;
  reg  [19:0] proute_q;
  reg  [31:0] mr_q [0:3];
  reg  [31:0] cr_q [0:3];

  reg         aw_full_q;
  reg         w_full_q;
  reg  [7:0]  waddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[8*k +: 8] = st[k] ? nw[8*k +: 8] : old[8*k +: 8];
      end
    end
  endfunction

  // ========================================================================
  // Write channel: address and data taken in either order
  wire wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready  = ~w_full_q;

  wire wr_mapped = (waddr_q[7:2] <= `TMRCC_PROUTE_OFF >> 2);
  wire wr_ir     = wr_go & (waddr_q == `TMRCC_IR_OFF);
  wire wr_tcr    = wr_go & (waddr_q == `TMRCC_TCR_OFF);
  wire wr_tc     = wr_go & (waddr_q == `TMRCC_TC_OFF);
  wire wr_emr    = wr_go & (waddr_q == `TMRCC_EMR_OFF);
  wire wr_mr     = wr_go & (waddr_q[7:4] == `TMRCC_MR0_OFF >> 4);
  wire [31:0] ir_wd  = merge({24'h000000, ir_q}, wdata_q, wstrb_q);
  wire [31:0] tcr_wd = merge({30'h0000000, tcr_q}, wdata_q, wstrb_q);
  wire [31:0] emr_wd = merge({20'h00000, emr_act_q, match_output}, wdata_q, wstrb_q);
  wire [31:0] mcr_wd = merge({20'h00000, mcr_q}, wdata_q, wstrb_q);
  wire [31:0] ccr_wd = merge({20'h00000, ccr_q}, wdata_q, wstrb_q);
  wire [31:0] prt_wd = merge({12'h000, proute_q}, wdata_q, wstrb_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q    <= 1'b0;
      w_full_q     <= 1'b0;
      waddr_q      <= 8'h00;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TMRCC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_full_q) begin
        aw_full_q <= 1'b1;
        waddr_q   <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & ~w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `TMRCC_RESP_OKAY : `TMRCC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Pin routing: several pins feed one capture, one match feeds many pins
  wire [3:0] cap_sig;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_route
      wire [7:0] msk = croute_q[8*gi +: 8];
      assign cap_sig[gi] = proute_q[gi] ? &(capture_input | ~msk)
                                        : |(capture_input & msk);
    end
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      assign match_pin[gi] = match_output[proute_q[4 + 2*gi +: 2]];
    end
  endgenerate

  // ========================================================================
  // Count source and prescaler
  wire       ext_mode = (ctcr_q[1:0] != `TMRCC_MODE_TIMER);
  wire [1:0] cnt_sel  = ctcr_q[`TMRCC_CTCR_SEL +: 2];
  wire       cnt_edge;

  // Only the one selected capture signal can clock the counter.
  tmrcc_edge u_cnt_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sig     (cap_sig[cnt_sel]),
    .rise_en (ctcr_q[0]),
    .fall_en (ctcr_q[1]),
    .evt     (cnt_edge)
  );

  // External clock is sampled each cycle, so edges one cycle apart still count separately.
  wire run     = tcr_q[`TMRCC_TCR_EN] & ~tcr_q[`TMRCC_TCR_RST];
  wire pc_step = run & (ext_mode ? cnt_edge : 1'b1);
  wire tick    = pc_step & (pc_q == pr_q);

  // ========================================================================
  // Match and capture events
  wire [3:0] hit;
  wire [3:0] cap_evt;
  wire [3:0] hit_rst;
  wire [3:0] hit_stop;
  wire [3:0] hit_int;
  wire [3:0] cap_int;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
      assign hit[gi]      = tick & (tc_q == mr_q[gi]);
      assign hit_rst[gi]  = hit[gi] & mcr_q[3*gi + `TMRCC_MCR_RST];
      assign hit_stop[gi] = hit[gi] & mcr_q[3*gi + `TMRCC_MCR_STOP];
      assign hit_int[gi]  = hit[gi] & mcr_q[3*gi + `TMRCC_MCR_INT];
      assign cap_int[gi]  = cap_evt[gi] & ccr_q[3*gi + `TMRCC_CCR_INT];

      // Every capture stays live whichever one drives the count.
      tmrcc_edge u_cap_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sig     (cap_sig[gi]),
        .rise_en (ccr_q[3*gi + `TMRCC_CCR_RISE]),
        .fall_en (ccr_q[3*gi + `TMRCC_CCR_FALL]),
        .evt     (cap_evt[gi])
      );

      tmrcc_emout u_emout (
        .aclk    (aclk),
        .aresetn (aresetn),
        .hit     (hit[gi]),
        .act     (emr_act_q[2*gi +: 2]),
        .sw_wr   (wr_emr),
        .sw_val  (emr_wd[gi]),
        .out_q   (match_output[gi])
      );

      always @(posedge aclk) begin
        if (!aresetn) begin
          mr_q[gi] <= 32'h00000000;
          cr_q[gi] <= 32'h00000000;
        end else begin
          if (wr_mr & (waddr_q[3:2] == gi)) begin
            mr_q[gi] <= merge(mr_q[gi], wdata_q, wstrb_q);
          end
          if (cap_evt[gi]) begin
            cr_q[gi] <= tc_q;
          end
        end
      end
    end
  endgenerate

  // ========================================================================
  // Counter, control and interrupt registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      ir_q      <= 8'h00;
      imr_q     <= 8'h00;
      tcr_q     <= 2'h0;
      tc_q      <= 32'h00000000;
      pr_q      <= 32'h00000000;
      pc_q      <= 32'h00000000;
      mcr_q     <= 12'h000;
      ccr_q     <= 12'h000;
      emr_act_q <= 8'h00;
      ctcr_q    <= 4'h0;
      croute_q  <= `TMRCC_CROUTE_RST;
      proute_q  <= {`TMRCC_PROUTE_RST, 4'h0};
    end else begin
      // New events beat a write-one-to-clear in the same cycle.
      ir_q <= (ir_q & ~(wr_ir ? ir_wd[7:0] : 8'h00)) | {cap_int, hit_int};

      // A stop from a match is never lost to a simultaneous write.
      if (wr_tcr) begin
        tcr_q <= tcr_wd[1:0] & ~{1'b0, |hit_stop};
      end else if (|hit_stop) begin
        tcr_q[`TMRCC_TCR_EN] <= 1'b0;
      end

      if (tcr_q[`TMRCC_TCR_RST]) begin
        tc_q <= 32'h00000000;
      end else if (wr_tc) begin
        tc_q <= merge(tc_q, wdata_q, wstrb_q);
      end else if (|hit_rst) begin
        tc_q <= 32'h00000000;
      end else if (tick & ~(|hit_stop)) begin
        tc_q <= tc_q + 32'h00000001;
      end

      if (tcr_q[`TMRCC_TCR_RST] | (|hit_rst) | wr_tc) begin
        pc_q <= 32'h00000000;
      end else if (pc_step) begin
        pc_q <= (pc_q == pr_q) ? 32'h00000000 : pc_q + 32'h00000001;
      end

      if (wr_go) begin
        case (waddr_q)
          `TMRCC_PR_OFF:     pr_q      <= merge(pr_q, wdata_q, wstrb_q);
          `TMRCC_MCR_OFF:    mcr_q     <= mcr_wd[11:0];
          `TMRCC_CCR_OFF:    ccr_q     <= ccr_wd[11:0];
          `TMRCC_EMR_OFF:    emr_act_q <= emr_wd[`TMRCC_EMR_ACT +: 8];
          `TMRCC_CTCR_OFF:   ctcr_q    <= wstrb_q[0] ? wdata_q[3:0] : ctcr_q;
          `TMRCC_IMR_OFF:    imr_q     <= wstrb_q[0] ? wdata_q[7:0] : imr_q;
          `TMRCC_CROUTE_OFF: croute_q  <= merge(croute_q, wdata_q, wstrb_q);
          `TMRCC_PROUTE_OFF: proute_q  <= prt_wd[19:0];
          default:           pr_q      <= pr_q;
        endcase
      end
    end
  end

  assign irq = |(ir_q & imr_q);

  // ========================================================================
  // Read channel
  reg [31:0] rd_mux;
  reg        rd_ok;
  wire [7:0] raddr = {s_axi_araddr[7:2], 2'b00};
  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rd_ok  = 1'b1;
    rd_mux = 32'h00000000;
    case (raddr)
      `TMRCC_IR_OFF:     rd_mux = {24'h000000, ir_q};
      `TMRCC_TCR_OFF:    rd_mux = {30'h0000000, tcr_q};
      `TMRCC_TC_OFF:     rd_mux = tc_q;
      `TMRCC_PR_OFF:     rd_mux = pr_q;
      `TMRCC_PC_OFF:     rd_mux = pc_q;
      `TMRCC_MCR_OFF:    rd_mux = {20'h00000, mcr_q};
      `TMRCC_CCR_OFF:    rd_mux = {20'h00000, ccr_q};
      `TMRCC_EMR_OFF:    rd_mux = {20'h00000, emr_act_q, match_output};
      `TMRCC_CTCR_OFF:   rd_mux = {28'h0000000, ctcr_q};
      `TMRCC_IMR_OFF:    rd_mux = {24'h000000, imr_q};
      `TMRCC_CROUTE_OFF: rd_mux = croute_q;
      `TMRCC_PROUTE_OFF: rd_mux = {12'h000, proute_q};
      default: begin
        if (raddr[7:4] == `TMRCC_MR0_OFF >> 4) begin
          rd_mux = mr_q[raddr[3:2]];
        end else if (raddr[7:4] == `TMRCC_CR0_OFF >> 4) begin
          rd_mux = cr_q[raddr[3:2]];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `TMRCC_RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? `TMRCC_RESP_OKAY : `TMRCC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // tmrcc_top

// >>> verification/tmrcc_properties.sv
// Checker for the timer's register bus, match pins and interrupt line.
// Assumes full-word writes and that it is bound to tmrcc_top.
`include "tmrcc_map.vh"
module tmrcc_props (
  input wire logic        aclk,          // Clock.
  input wire logic        aresetn,       // Reset, active low.
  input wire logic [7:0]  s_axi_awaddr,  // Write address.
  input wire logic        s_axi_awvalid, // Address valid.
  input wire logic        s_axi_awready, // Address ready.
  input wire logic [31:0] s_axi_wdata,   // Write data.
  input wire logic        s_axi_wvalid,  // Data valid.
  input wire logic        s_axi_wready,  // Data ready.
  input wire logic [1:0]  s_axi_bresp,   // Write response.
  input wire logic        s_axi_bvalid,  // Response valid.
  input wire logic        s_axi_bready,  // Response ready.
  input wire logic [7:0]  s_axi_araddr,  // Read address.
  input wire logic        s_axi_arvalid, // Address valid.
  input wire logic        s_axi_arready, // Address ready.
  input wire logic [31:0] s_axi_rdata,   // Read data.
  input wire logic [1:0]  s_axi_rresp,   // Read response.
  input wire logic        s_axi_rvalid,  // Read valid.
  input wire logic        s_axi_rready,  // Read ready.
  input wire logic [3:0]  match_output,  // Match outputs.
  input wire logic [7:0]  match_pin,     // Routed pins.
  input wire logic        irq            // Interrupt.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  wa_q;
  logic [31:0] wd_q;
  logic [31:0] prt_q;
  logic [31:0] imr_q;
  logic [7:0]  pin_x;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Shadow registers
  // The copy lags the design until the response is taken, so the checks
  // that use it pause while bvalid stands.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prt_q <= {12'h0, `TMRCC_PROUTE_RST, 4'h0};
      imr_q <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
      if (s_axi_bvalid && s_axi_bready && wa_q == `TMRCC_PROUTE_OFF) prt_q <= wd_q;
      if (s_axi_bvalid && s_axi_bready && wa_q == `TMRCC_IMR_OFF) imr_q <= wd_q;
    end
  end
  always_comb begin
    for (int j = 0; j < 8; j++) pin_x[j] = match_output[prt_q[4 + 2 * j +: 2]];
  end
  // ==========================================================================
  // Assertions
  a_pin_route: assert property (!s_axi_bvalid |-> match_pin == pin_x)
    else $error("match pin differs from its routed match output");
  a_irq_masked: assert property (imr_q[7:0] == 8'h0 && !s_axi_bvalid |-> !irq)
    else $error("interrupt raised while every source is masked");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data did not follow the address by one cycle");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data pending");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before it was taken");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before it was taken");
  a_write_answer: assert property ($rose(s_axi_bvalid) |->
      $past(!s_axi_awready && !s_axi_wready))
    else $error("write response without both address and data held");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[7:2] > 6'h13 |=> s_axi_rresp == `TMRCC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused with zero data");
endmodule // tmrcc_props

bind tmrcc_top tmrcc_props tmrcc_props_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .match_output(match_output), .match_pin(match_pin), .irq(irq));

// >>> verification/tmrcc_pins.sv
// Pin-side model: quiet capture levels plus a burst of pulses on one pin.
// Assumes its inputs change just after rising edges of aclk.
module tmrcc_pins (
  input  wire logic       aclk,          // Clock.
  input  wire logic       go,            // Start a burst.
  input  wire logic [2:0] sel,           // Pin carrying the burst.
  input  wire logic [7:0] npul,          // Pulses in a burst.
  input  wire logic [2:0] half,          // Cycles per level.
  input  wire logic [7:0] lvl,           // Quiet pin levels.
  output wire logic [7:0] capture_input, // Pins seen by the timer.
  output wire logic       busy           // Burst under way.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] ph_q = 9'h0;
  logic [2:0] cnt_q = 3'h0;
  logic       tog_q = 1'b0;
  wire  [2:0] hmin = (half < 3'h2) ? 3'h2 : half;
  // ==========================================================================
  // Burst generator
  // No level lasts under two cycles, so the count clock never beats a
  // quarter of aclk.
  always_ff @(posedge aclk) begin
    if (go && !busy) begin
      ph_q <= {npul, 1'b0};
      cnt_q <= hmin;
    end else if (busy) begin
      if (cnt_q < 3'h2) begin
        tog_q <= ~tog_q;
        ph_q <= ph_q - 9'h1;
        cnt_q <= hmin;
      end else begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
  assign busy = ph_q != 9'h0;
  assign capture_input = lvl ^ (8'(tog_q) << sel);
endmodule // tmrcc_pins

// >>> verification/tmrcc_tb.sv
// Self-checking bench for the capture/match timer.
// Assumes the design files, checker and pin model are compiled before it.
`include "tmrcc_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, busy;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, cin, mpin, lvl = 8'h0, npul = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, q, l, m, p, ch, k, n;
  logic [1:0] bresp, rresp, r;
  logic [3:0] mout;
  logic [2:0] psel = 3'h4, half = 3'h2;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  logic [7:0] roff[4] = '{`TMRCC_CROUTE_OFF, `TMRCC_PROUTE_OFF, `TMRCC_TCR_OFF, `TMRCC_IMR_OFF};
  logic [31:0] rval[4] = '{`TMRCC_CROUTE_RST, {12'h0, `TMRCC_PROUTE_RST, 4'h0}, 0, 0};
  always #25 aclk = ~aclk;
  tmrcc_top tmrcc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .capture_input(cin),
    .match_output(mout), .match_pin(mpin), .irq(irq));
  tmrcc_pins tmrcc_pins_inst (.aclk(aclk), .go(go), .sel(psel), .npul(npul),
    .half(half), .lvl(lvl), .capture_input(cin), .busy(busy));
  // ==========================================================================
  // Tasks
  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Outputs are sampled at the falling edge, where the design is settled.
  task automatic axi(input bit is_rd, input logic [7:0] a, input logic [31:0] d);
    bit pa, pw, ha, hw, hr;
    pa = 1'b1;
    pw = !is_rd;
    @(posedge aclk);
    rready <= is_rd;
    bready <= !is_rd;
    if (is_rd) begin
      araddr <= a;
      arvalid <= 1'b1;
    end else begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
    end
    do begin
      @(negedge aclk);
      ha = pa && (is_rd ? arready : awready);
      hw = pw && wready;
      hr = is_rd ? rvalid : bvalid;
      q = rdata;
      r = is_rd ? rresp : bresp;
      @(posedge aclk);
      if (ha) begin
        pa = 1'b0;
        arvalid <= 1'b0;
        awvalid <= 1'b0;
      end
      if (hw) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!hr);
    rready <= 1'b0;
    bready <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    axi(1'b0, a, d);
  endtask
  task automatic rreg(input logic [7:0] a);
    axi(1'b1, a, 32'h0);
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  function automatic logic [63:0] cnt_x(input int ev, input int pr, input int mr);
    return {32'(ev / (pr + 1) % (mr + 1)), 32'(ev % (pr + 1))};
  endfunction
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(85244));
    rst();
    foreach (roff[i]) begin
      rreg(roff[i]);
      chk(q, rval[i]);
    end
    rreg(8'h50);
    chk({r, q}, {`TMRCC_RESP_SLVERR, 32'h0});
    wreg(8'h50, 32'h1);
    chk(r, `TMRCC_RESP_SLVERR);
    // Four matches on one tick: three run on, the last stops the count.
    l = $urandom;
    p = $urandom % 4;
    m = 5 + $urandom % 16;
    lvl <= {4'h0, l[3:0]};
    wreg(`TMRCC_PR_OFF, p);
    for (int i = 0; i < 4; i++) wreg(8'(`TMRCC_MR0_OFF + 4 * i), m);
    wreg(`TMRCC_MCR_OFF, 32'ha49);
    wreg(`TMRCC_EMR_OFF, {20'h0, 8'he4, l[3:0]});
    wreg(`TMRCC_TCR_OFF, 32'h1);
    repeat ((m + 2) * (p + 1) + 4) @(posedge aclk);
    rreg(`TMRCC_TC_OFF);
    chk(q, m);
    rreg(`TMRCC_TCR_OFF);
    chk(q, 32'h0);
    rreg(`TMRCC_IR_OFF);
    chk(q, 32'hf);
    @(negedge aclk);
    chk(mout, {~l[3], 2'b10, l[0]});
    chk(mpin, {2{~l[3], 2'b10, l[0]}});
    chk(irq, 1'b0);
    wreg(`TMRCC_IMR_OFF, 32'h8);
    @(negedge aclk);
    chk(irq, 1'b1);
    wreg(`TMRCC_IR_OFF, 32'h8);
    @(negedge aclk);
    chk(irq, 1'b0);
    wreg(`TMRCC_CCR_OFF, 32'h5);
    lvl <= lvl | 8'h10;
    repeat (4) @(posedge aclk);
    rreg(`TMRCC_CR0_OFF);
    chk(q, m);
    rreg(`TMRCC_IR_OFF);
    chk(q, 32'h17);
    // Event counting in each edge mode, with a second channel capturing.
    for (int md = 1; md < 4; md++) begin
      rst();
      lvl <= {4'h0, 4'($urandom)};
      p = $urandom % 3;
      m = 3 + $urandom % 7;
      ch = $urandom % 4;
      k = (ch + 1) % 4;
      n = 8 + $urandom % 24;
      wreg(`TMRCC_PR_OFF, p);
      wreg(`TMRCC_MR0_OFF, m);
      wreg(`TMRCC_MCR_OFF, 32'h2);
      wreg(`TMRCC_CCR_OFF, 32'h5 << (3 * k));
      wreg(`TMRCC_CTCR_OFF, md | (ch << 2));
      wreg(`TMRCC_TCR_OFF, 32'h1);
      psel <= 3'(4 + ch);
      npul <= n[7:0];
      half <= 3'(2 + $urandom % 3);
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (6) @(posedge aclk);
      lvl <= lvl | (8'h10 << k);
      do @(negedge aclk); while (busy);
      repeat (4) @(posedge aclk);
      rreg(`TMRCC_TC_OFF);
      chk(q, cnt_x(md == 3 ? 2 * n : n, p, m) >> 32);
      rreg(`TMRCC_PC_OFF);
      chk(q, cnt_x(md == 3 ? 2 * n : n, p, m) & 64'hffffffff);
      rreg(`TMRCC_IR_OFF);
      chk(q, 32'h10 << k);
    end
    // Matches spread over the pins; capture 1 needs two pins high at once.
    rst();
    lvl <= 8'h0;
    l = $urandom;
    k = $urandom;
    wreg(`TMRCC_EMR_OFF, {28'h0, l[3:0]});
    wreg(`TMRCC_PROUTE_OFF, {12'h0, k[15:0], 4'h2});
    wreg(`TMRCC_CROUTE_OFF, 32'h80403010);
    wreg(`TMRCC_CCR_OFF, 32'h28);
    lvl <= 8'h10;
    @(negedge aclk);
    for (int j = 0; j < 8; j++) chk(mpin[j], l[k[2 * j +: 2]]);
    repeat (3) @(posedge aclk);
    rreg(`TMRCC_IR_OFF);
    chk(q, 32'h0);
    lvl <= 8'h30;
    repeat (3) @(posedge aclk);
    rreg(`TMRCC_IR_OFF);
    chk(q, 32'h20);
    print_verdict();
  end
endmodule // testbench
